// >>> hdl/ssdc_ctrl.sv
// Serial control and fault reporting of a six-channel low-side driver
//
// Contract
// - Shift serial input each rising serial clock
// - Control bit one switches channel on
// - Select rise latches last six bits
// - Select rise releases serial output
// - Select rise resumes live fault tracking
// - Output bit is fault XOR input bit
// - Set fault inverts matching input bit
// - Fault word: channels 0-5, overtemp 6
// - Fault bits follow live state while deselected
// - Fault word sampled at select fall
// - Fault word frozen while selected
// - Open-load when off, short when on
// - Shorted channel driven with low-duty pulses
// - Output bits shift on rising serial clock
// - Serial clock ignored while deselected
// - Power-on reset clears internal registers, except the select synchroniser, which is set to deselected
// - Frames travel most significant bit first
// - Battery over-voltage disables all channels
// - Sixteen-bit frame: overtemp at bit 14
// - Overtemp never changes channel state
`timescale 1ns/1ps
`default_nettype none
module ssdc_ctrl
  import ssdc_pkg::*;
#(
  parameter int unsigned PWM_PERIOD_CYC = SENSE_CYCLE_CYC,
  parameter int unsigned PWM_PULSE_CYC  = SENSE_PULSE_CYC
) (
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  input  wire logic       sclk_in,
  input  wire logic       cs_n_in,
  input  wire logic       serial_in_in,
  input  wire logic [5:0] short_fault_in,
  input  wire logic [5:0] open_load_in,
  input  wire logic       over_temp_in,
  input  wire logic       over_voltage_in,
  output var  logic       channel0_output_out,
  output var  logic       channel1_output_out,
  output var  logic       channel2_output_out,
  output var  logic       channel3_output_out,
  output var  logic       channel4_output_out,
  output var  logic       channel5_output_out,
  output var  logic       serial_out_out,
  output var  logic       serial_out_oe_out
);

  ssdc_sys_t  sys_q;
  ssdc_sys_t  sys_d;
  ssdc_link_t ln_q;
  ssdc_link_t ln_d;
  logic [15:0] sh_q;
  logic [15:0] sh_d;
  logic        pwm_pulse;
  logic [5:0]  live_fault;
  logic [5:0]  gated_on;

  // Fault pattern for a frame position; only the first byte carries flags
  function automatic logic fault_bit(input logic [4:0] pos, input logic [6:0] f);
    logic [7:0] fb;
    fb = {1'b0, f};
    if (pos < FAULT_BYTE_END) begin
      fault_bit = fb[~pos[2:0]];
    end else begin
      fault_bit = 1'b0;
    end
  endfunction

  // ---------------- Serial clock domain ----------------

  // The link registers are clocked only by the serial clock, which stops
  // between frames, so the per-frame count is cleared by deselect itself.
  always_comb begin
    ln_d = ln_q;
    if (ln_q.cnt != FRAME_CNT_MAX) begin
      ln_d.cnt = ln_q.cnt + 5'h01;
    end
    // Fault word is frozen by the system domain before the first edge
    ln_d.sout = serial_in_in ^ fault_bit(ln_q.cnt, sys_q.fault);
  end

  always_ff @(posedge sclk_in or posedge reset_in or posedge cs_n_in) begin
    if (reset_in || cs_n_in) begin
      ln_q <= '0;
    end else begin
      ln_q <= ln_d;
    end
  end

  // Shift register survives deselect so the system domain can latch it
  always_comb begin
    if (cs_n_in) begin
      sh_d = sh_q;
    end else begin
      sh_d = {sh_q[14:0], serial_in_in};
    end
  end

  always_ff @(posedge sclk_in or posedge reset_in) begin
    if (reset_in) begin
      sh_q <= SHIFT_RESET;
    end else begin
      sh_q <= sh_d;
    end
  end

  // ---------------- System clock domain ----------------

  ssdc_pwm #(
    .PERIOD_CYC (PWM_PERIOD_CYC),
    .PULSE_CYC  (PWM_PULSE_CYC)
  ) u_pwm (
    .clk_in    (clk_in),
    .reset_in  (reset_in),
    .pulse_out (pwm_pulse)
  );

  genvar ch;
  generate
    for (ch = 0; ch < CH_COUNT; ch++) begin : g_ch
      // Off channels report open load, on channels report shorts
      assign live_fault[ch] = sys_q.latch[ch] ? sys_q.short_s2[ch]
                                              : sys_q.open_s2[ch];
      // Shorted channel is chopped by the shared low-duty pattern
      assign gated_on[ch] = sys_q.latch[ch] &
                            (~sys_q.short_s2[ch] | pwm_pulse);
    end
  endgenerate

  always_comb begin
    sys_d = sys_q;
    sys_d.cs_s1    = cs_n_in;
    sys_d.cs_s2    = sys_q.cs_s1;
    sys_d.cs_s3    = sys_q.cs_s2;
    sys_d.short_s1 = short_fault_in;
    sys_d.short_s2 = sys_q.short_s1;
    sys_d.open_s1  = open_load_in;
    sys_d.open_s2  = sys_q.open_s1;
    sys_d.ot_s1    = over_temp_in;
    sys_d.ot_s2    = sys_q.ot_s1;
    sys_d.ov_s1    = over_voltage_in;
    sys_d.ov_s2    = sys_q.ov_s1;
    // Tracks live faults while deselected, holds from the select fall on
    if (sys_q.cs_s2) begin
      sys_d.fault = {sys_q.ot_s2, live_fault};
    end
    // Select rise: the link clock has stopped, so the shift word is stable
    if (sys_q.cs_s2 && !sys_q.cs_s3) begin
      sys_d.latch = sh_q[5:0];
    end
    // Over-temperature is reported only and does not enter this term
    if (sys_q.ov_s2) begin
      sys_d.drive = 6'h00;
    end else begin
      sys_d.drive = gated_on;
    end
    sys_d.oe = !sys_q.cs_s2;
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      sys_q <= '{cs_s1: 1'b1, cs_s2: 1'b1, cs_s3: 1'b1,
                 short_s1: 6'h00, short_s2: 6'h00, open_s1: 6'h00, open_s2: 6'h00,
                 ot_s1: 1'b0, ot_s2: 1'b0, ov_s1: 1'b0, ov_s2: 1'b0,
                 fault: FAULT_RESET, latch: LATCH_RESET, drive: 6'h00,
                 oe: 1'b0};
    end else begin
      sys_q <= sys_d;
    end
  end

  assign channel0_output_out = sys_q.drive[0];
  assign channel1_output_out = sys_q.drive[1];
  assign channel2_output_out = sys_q.drive[2];
  assign channel3_output_out = sys_q.drive[3];
  assign channel4_output_out = sys_q.drive[4];
  assign channel5_output_out = sys_q.drive[5];
  assign serial_out_out      = ln_q.sout;
  assign serial_out_oe_out   = sys_q.oe;

  // ---------------- Checks ----------------

  a_shift_sample: assert property (
    @(posedge sclk_in) disable iff (reset_in || cs_n_in)
    1'b1 |=> sh_q[0] == $past(serial_in_in) && sh_q[15:1] == $past(sh_q[14:0]))
    else $error("shift register did not take the serial input");

  a_ot_position: assert property (
    @(posedge sclk_in) disable iff (reset_in || cs_n_in)
    ln_q.cnt == 5'h01 |=> serial_out_out == ($past(serial_in_in) ^ sys_q.fault[6]))
    else $error("overtemp flag not at second output position");

  a_ch5_position: assert property (
    @(posedge sclk_in) disable iff (reset_in || cs_n_in)
    ln_q.cnt == 5'h02 |=> serial_out_out == ($past(serial_in_in) ^ sys_q.fault[5]))
    else $error("channel 5 fault not at third output position");

  // The last edge of a long frame is left out: its next edge belongs to the
  // next frame, where the output bit has already been cleared by deselect
  a_pass_through: assert property (
    @(posedge sclk_in) disable iff (reset_in || cs_n_in)
    (ln_q.cnt == 5'h00 || (ln_q.cnt >= 5'h08 && ln_q.cnt < 5'h0F))
      |=> serial_out_out == $past(serial_in_in))
    else $error("flagless position did not pass input through");

  a_latch_rise: assert property (
    @(posedge clk_in) disable iff (reset_in)
    $rose(sys_q.cs_s2) |=> sys_q.latch == sh_q[5:0])
    else $error("output latch missed the select rise");

  a_oe_release: assert property (
    @(posedge clk_in) disable iff (reset_in)
    sys_q.cs_s2 |=> !serial_out_oe_out)
    else $error("serial output still driven while deselected");

  a_fault_freeze: assert property (
    @(posedge clk_in) disable iff (reset_in)
    !sys_q.cs_s2 ##1 !sys_q.cs_s2 |-> $stable(sys_q.fault))
    else $error("fault word changed during a frame");

  a_fault_track: assert property (
    @(posedge clk_in) disable iff (reset_in)
    sys_q.cs_s2 |=> sys_q.fault == {$past(sys_q.ot_s2), $past(live_fault)})
    else $error("fault word not tracking live faults");

  a_ov_disable: assert property (
    @(posedge clk_in) disable iff (reset_in)
    sys_q.ov_s2 |=> sys_q.drive == 6'h00)
    else $error("channel driven during battery over-voltage");

  a_ch_follow: assert property (
    @(posedge clk_in) disable iff (reset_in)
    (!sys_q.ov_s2 && sys_q.short_s2 == 6'h00) |=> sys_q.drive == $past(sys_q.latch))
    else $error("channel state differs from latched control");

  a_pwm_short: assert property (
    @(posedge clk_in) disable iff (reset_in)
    (!sys_q.ov_s2 && sys_q.latch[0] && sys_q.short_s2[0])
      |=> channel0_output_out == $past(pwm_pulse))
    else $error("shorted channel not following pulse pattern");

  c_frame_short: cover property (
    @(posedge sclk_in) disable iff (reset_in || cs_n_in) ln_q.cnt == 5'h08);

  c_frame_long: cover property (
    @(posedge sclk_in) disable iff (reset_in || cs_n_in) ln_q.cnt == 5'h10);

  c_latch_on: cover property (
    @(posedge clk_in) disable iff (reset_in) $rose(sys_q.cs_s2) ##1 sys_q.latch != 6'h00);

  c_ov_cut: cover property (
    @(posedge clk_in) disable iff (reset_in) sys_q.ov_s2 && sys_q.latch != 6'h00);

  c_pwm_chop: cover property (
    @(posedge clk_in) disable iff (reset_in)
    sys_q.latch[0] && sys_q.short_s2[0] && $fell(pwm_pulse));

endmodule
`default_nettype wire

// >>> hdl/ssdc_pkg.sv
// Shared constants and state types of the serial six-channel driver control block
package ssdc_pkg;

  // Channel and frame geometry
  localparam int unsigned CH_COUNT       = 6;
  localparam int unsigned FRAME_SHORT    = 8;
  localparam int unsigned FRAME_LONG     = 16;
  localparam int unsigned FAULT_OT_BIT   = 6;
  localparam logic [4:0]  FRAME_CNT_MAX  = 5'h10;
  localparam logic [4:0]  FAULT_BYTE_END = 5'h08;

  // Values after reset
  localparam logic [5:0]  LATCH_RESET    = 6'h00;
  localparam logic [6:0]  FAULT_RESET    = 7'h00;
  localparam logic [15:0] SHIFT_RESET    = 16'h0000;

  // Timing of the shorted-channel pulse pattern
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned SENSE_PULSE_NS = 70000;
  localparam int unsigned SENSE_CYCLE_NS = 4000000;
  localparam int unsigned SENSE_PULSE_CYC = SENSE_PULSE_NS / CLK_PERIOD_NS;
  localparam int unsigned SENSE_CYCLE_CYC = SENSE_CYCLE_NS / CLK_PERIOD_NS;

  // System clock domain state
  typedef struct packed {
    logic       cs_s1;
    logic       cs_s2;
    logic       cs_s3;
    logic [5:0] short_s1;
    logic [5:0] short_s2;
    logic [5:0] open_s1;
    logic [5:0] open_s2;
    logic       ot_s1;
    logic       ot_s2;
    logic       ov_s1;
    logic       ov_s2;
    logic [6:0] fault;
    logic [5:0] latch;
    logic [5:0] drive;
    logic       oe;
  } ssdc_sys_t;

  // Serial clock domain, frame-scoped state
  typedef struct packed {
    logic [4:0] cnt;
    logic       sout;
  } ssdc_link_t;

  // Pulse pattern generator state
  typedef struct packed {
    logic [31:0] cnt;
    logic        pulse;
  } ssdc_pwm_t;

endpackage

// >>> hdl/ssdc_pwm.sv
// Low-duty pulse pattern generator used to chop shorted channels
`timescale 1ns/1ps
`default_nettype none
module ssdc_pwm
  import ssdc_pkg::*;
#(
  parameter int unsigned PERIOD_CYC = SENSE_CYCLE_CYC,
  parameter int unsigned PULSE_CYC  = SENSE_PULSE_CYC
) (
  input  wire logic clk_in,
  input  wire logic reset_in,
  output var  logic pulse_out
);

  ssdc_pwm_t q;
  ssdc_pwm_t d;

  always_comb begin
    d = q;
    if (q.cnt >= 32'(PERIOD_CYC - 1)) begin
      d.cnt = 32'h0000_0000;
    end else begin
      d.cnt = q.cnt + 32'h0000_0001;
    end
    d.pulse = (d.cnt < 32'(PULSE_CYC));
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign pulse_out = q.pulse;

endmodule
`default_nettype wire

// >>> tb/ssdc_link_master.sv
// Controller model that drives the serial link of the driver block
`timescale 1ns/1ps
`default_nettype none
module ssdc_link_master (
  output var  logic sclk_out,
  output var  logic cs_n_out,
  output var  logic serial_in_out,
  input  wire logic serial_out_in
);
  initial begin
    sclk_out      = 1'b0;
    cs_n_out      = 1'b1;
    serial_in_out = 1'b0;
  end

  // Sends len bits, most significant first, and collects the returned bits
  task automatic xfer(input logic [15:0] data, input logic [4:0] len, output logic [15:0] got);
    got = 16'h0000;
    cs_n_out = 1'b0;
    // Setup covers the select synchroniser of the system clock domain
    #200;
    for (int i = int'(len) - 1; i >= 0; i--) begin
      serial_in_out = data[i];
      #16 sclk_out = 1'b1;
      #16 got[i] = serial_out_in;
      sclk_out = 1'b0;
    end
    #16 cs_n_out = 1'b1;
    // Released line falls to its pull-down level
    serial_in_out = 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> tb/test_serial_six_channel_driver_ctrl.sv
// Self-checking bench of the serial six-channel driver control block
`timescale 1ns/1ps
`default_nettype none
module test_serial_six_channel_driver_ctrl;
  import ssdc_pkg::*;
  localparam int unsigned PER = 20;
  localparam int unsigned PUL = 3;
  typedef struct packed {
    logic [15:0] data;
    logic [4:0]  len;
    logic [5:0]  shrt;
    logic [5:0]  opn;
    logic        ot;
  } ssdc_row_t;
  logic        clk_in    = 1'b0;
  logic        reset_in  = 1'b1;
  logic        sclk, cs_n, sin, sout, soe;
  logic        ot        = 1'b0;
  logic        ov        = 1'b0;
  logic [5:0]  short_f   = 6'h00;
  logic [5:0]  open_f    = 6'h00;
  logic [5:0]  chan;
  logic [5:0]  latch_m   = 6'h00;
  logic [15:0] got, n;
  int          bad_count   = 0;
  int          check_count = 0;
  // Latch state before each row decides which fault kind is reported
  ssdc_row_t   rows [4] = '{
    '{16'h003F, 5'h08, 6'h00, 6'h15, 1'b0},
    '{16'h0015, 5'h08, 6'h0A, 6'h3F, 1'b1},
    '{16'h002A, 5'h10, 6'h15, 6'h2A, 1'b1},
    '{16'h80C0, 5'h10, 6'h00, 6'h00, 1'b0}};

  always #5 clk_in = ~clk_in;

  ssdc_link_master master (.sclk_out(sclk), .cs_n_out(cs_n), .serial_in_out(sin),
    .serial_out_in(sout));

  ssdc_ctrl #(.PWM_PERIOD_CYC(PER), .PWM_PULSE_CYC(PUL)) dut (
    .clk_in(clk_in), .reset_in(reset_in), .sclk_in(sclk), .cs_n_in(cs_n),
    .serial_in_in(sin), .short_fault_in(short_f), .open_load_in(open_f),
    .over_temp_in(ot), .over_voltage_in(ov),
    .channel0_output_out(chan[0]), .channel1_output_out(chan[1]),
    .channel2_output_out(chan[2]), .channel3_output_out(chan[3]),
    .channel4_output_out(chan[4]), .channel5_output_out(chan[5]),
    .serial_out_out(sout), .serial_out_oe_out(soe));

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] seen);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  function automatic logic [15:0] exp_out(input ssdc_row_t r);
    logic [7:0] f;
    f = {1'b0, r.ot, (latch_m & r.shrt) | (~latch_m & r.opn)};
    return (r.len == 5'h10) ? (r.data ^ {f, 8'h00}) : (r.data ^ {8'h00, f});
  endfunction

  task automatic frame(input logic [15:0] d, input logic [4:0] len, input logic [15:0] e);
    master.xfer(d, len, got);
    check("serial_out", e, got);
    repeat (10) @(negedge clk_in);
    check("released", 16'h0000, {14'h0000, soe, sout});
    check("channels", {10'h000, d[5:0]}, {10'h000, chan});
    latch_m = d[5:0];
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    #100000;
    bad_count++;
    $display("unexpected timeout: expected end seen hang");
    results();
  end

  initial begin
    repeat (2) @(negedge clk_in);
    check("reset", 16'h0000, {9'h000, soe, chan});
    repeat (2) @(negedge clk_in);
    reset_in = 1'b0;
    repeat (6) @(negedge clk_in);
    foreach (rows[k]) begin
      short_f = rows[k].shrt;
      open_f  = rows[k].opn;
      ot      = rows[k].ot;
      repeat (6) @(negedge clk_in);
      frame(rows[k].data, rows[k].len, exp_out(rows[k]));
      $display("row %0d done", k);
    end
    // A fault that arises mid-frame stays out of that frame
    fork
      frame(16'h0000, 5'h08, 16'h0000);
      begin
        repeat (25) @(negedge clk_in);
        check("selected_oe", 16'h0001, {15'h0000, soe});
        open_f = 6'h3F;
      end
    join
    frame(16'h003F, 5'h08, 16'h0000);
    open_f = 6'h00;
    $display("frozen fault test done");
    ov = 1'b1;
    repeat (6) @(negedge clk_in);
    check("overvoltage", 16'h0000, {10'h000, chan});
    ov = 1'b0;
    ot = 1'b1;
    repeat (6) @(negedge clk_in);
    check("resume", 16'h003F, {10'h000, chan});
    ot = 1'b0;
    $display("overvoltage test done");
    short_f = 6'h01;
    repeat (2 * PER) @(negedge clk_in);
    n = 16'h0000;
    repeat (PER) begin
      @(negedge clk_in);
      n = n + {15'h0000, chan[0]};
    end
    check("pulse", 16'(PUL), n);
    check("others", 16'h001F, {11'h000, chan[5:1]});
    $display("pulse test done");
    results();
  end
endmodule
`default_nettype wire
